/* File: src/pmcb_regs.svh */
`ifndef PMCB_REGS_SVH
`define PMCB_REGS_SVH

// Logical device numbers seen on the logical_device input
`define PMCB_LDN_PARALLEL 8'h03
`define PMCB_LDN_SERIAL1 8'h04

// Register offsets
`define PMCB_OFF_PP_MODE 8'hf0
`define PMCB_OFF_PP_OPT 8'hf1
`define PMCB_OFF_SP1_MODE 8'hf0
`define PMCB_OFF_INT_STAT 8'hfe
`define PMCB_OFF_INT_MASK 8'hff

// Reset values
`define PMCB_PP_MODE_RST 8'h3c
`define PMCB_PP_OPT_RST 8'h00
`define PMCB_SP1_RST 8'h00
`define PMCB_INT_RST 2'h0
`define PMCB_BYTE_ZERO 8'h00

// Writable bits; reserved bits read as zero
`define PMCB_PP_OPT_MASK 8'h10
`define PMCB_SP1_MASK 8'h83

// Field positions
`define PMCB_PP_MODE_MSB 2
`define PMCB_PP_MODE_LSB 0
`define PMCB_PP_THR_MSB 6
`define PMCB_PP_THR_LSB 3
`define PMCB_PP_ITYPE_BIT 7
`define PMCB_PP_TOSEL_BIT 4
`define PMCB_SP1_MIDI_BIT 0
`define PMCB_SP1_HS_BIT 1
`define PMCB_SP1_SHARE_BIT 7
`define PMCB_EPP_TIMEOUT_BIT 0
`define PMCB_INT_TIMEOUT_BIT 0
`define PMCB_INT_PPIRQ_BIT 1
`define PMCB_INT_MSB 1

// Timing
`define PMCB_CLK_NS 25
`define PMCB_IRQ_PULSE_NS 100
`define PMCB_IRQ_PULSE_CYC ((`PMCB_IRQ_PULSE_NS + `PMCB_CLK_NS - 1) / `PMCB_CLK_NS)
`define PMCB_CNT_ZERO 3'h0

`endif

/* File: src/pmcb_pkg.sv */
`default_nettype none
package pmcb_pkg;

  typedef enum logic [2:0] {
    PM_SPP = 3'h0,
    PM_EPP19 = 3'h1,
    PM_ECP = 3'h2,
    PM_ECP_EPP19 = 3'h3,
    PM_PRINTER = 3'h4,
    PM_EPP17 = 3'h5,
    PM_RSVD = 3'h6,
    PM_ECP_EPP17 = 3'h7
  } pmcb_ppmode_t;

  typedef enum logic [1:0] {
    PS_IDLE = 2'h1,
    PS_LOW = 2'h2
  } pmcb_pulse_t;

  typedef struct packed {
    logic [7:0] pp_mode;
    logic [7:0] pp_opt;
    logic [7:0] sp1_mode;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic [7:0] rdata;
    logic timeout;
    logic rd_prev;
    logic req_prev;
    pmcb_pulse_t pulse_st;
    logic [2:0] pulse_cnt;
    logic pp_irq_out;
    logic pp_irq_oe;
    logic uart1_irq;
    logic uart2_irq;
    logic cfg_irq;
  } pmcb_state_t;

endpackage : pmcb_pkg
`default_nettype wire

/* File: src/pmcb_sync.sv */
`default_nettype none
module pmcb_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : pmcb_sync
`default_nettype wire

/* File: src/pmcb_bank.sv */
// What this block does
// - Mode 100 printer, 000 SPP, 010 ECP
// - Mode 001 EPP 1.9, 101 EPP 1.7
// - Mode 011 ECP+EPP1.9, 111 ECP+EPP1.7
// - FIFO threshold bits 6:3, reset 0111
// - Type one: pulse low, then release
// - Type zero: follow nACK or level
// - Type bit ignored in printer, SPP
// - Select zero: clear flag on write one
// - Select one: clear after status read ends
// - Bit zero enables serial MIDI support
// - Bit one enables serial high speed
// - Share bit merges both UART requests
// - Shared with two IRQs: both assert
`include "pmcb_regs.svh"
`default_nettype none
module pmcb_bank (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] logical_device,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic nack_n,
  input wire logic ecp_fifo_mode,
  input wire logic pp_irq_req,
  input wire logic epp_timeout_evt,
  input wire logic epp_status_rd,
  input wire logic epp_status_wr,
  input wire logic [7:0] epp_status_wdata,
  input wire logic uart1_irq_req,
  input wire logic uart2_irq_req,
  output logic [2:0] pp_mode,
  output logic [3:0] ecp_fifo_threshold,
  output logic epp_timeout_flag,
  output logic pp_irq_out,
  output logic pp_irq_oe,
  output logic uart1_midi_en,
  output logic uart1_high_speed,
  output logic uart1_irq,
  output logic uart2_irq,
  output logic cfg_irq
);
  import pmcb_pkg::*;

  pmcb_state_t s;
  pmcb_state_t next_s;
  logic nack_s;
  logic sel_pp;
  logic sel_sp1;
  logic basic;
  logic itype;
  logic tosel;
  logic req;
  logic trigger;
  logic timeout_clr;
  logic [1:0] int_set;
  logic [1:0] int_clr;
  pmcb_ppmode_t mode;

  function automatic logic pmcb_is_ecp(input pmcb_ppmode_t m);
    return (m == PM_ECP) || (m == PM_ECP_EPP19) || (m == PM_ECP_EPP17);
  endfunction : pmcb_is_ecp

  function automatic logic pmcb_is_basic(input pmcb_ppmode_t m);
    // Reserved code 110 behaves like printer mode
    return (m == PM_PRINTER) || (m == PM_SPP) || (m == PM_RSVD);
  endfunction : pmcb_is_basic

  pmcb_sync #(
    .RST_VAL(1'b1)
  ) u_nack_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(nack_n),
    .q(nack_s)
  );

  assign mode = pmcb_ppmode_t'(s.pp_mode[`PMCB_PP_MODE_MSB:`PMCB_PP_MODE_LSB]);
  assign sel_pp = (logical_device == `PMCB_LDN_PARALLEL);
  assign sel_sp1 = (logical_device == `PMCB_LDN_SERIAL1);
  assign basic = pmcb_is_basic(mode);
  assign itype = s.pp_mode[`PMCB_PP_ITYPE_BIT];
  assign tosel = s.pp_opt[`PMCB_PP_TOSEL_BIT];

  always_comb begin
    next_s = s;
    // ECP request only counts in its FIFO sub-modes; elsewhere nACK drives it
    if (pmcb_is_ecp(mode) && ecp_fifo_mode) begin
      req = pp_irq_req;
    end else begin
      req = ~nack_s;
    end
    trigger = req && !s.req_prev;
    next_s.req_prev = req;

    // Timeout flag: set beats clear so no event is lost
    if (tosel) begin
      timeout_clr = s.rd_prev && !epp_status_rd;
    end else begin
      timeout_clr = epp_status_wr && epp_status_wdata[`PMCB_EPP_TIMEOUT_BIT];
    end
    next_s.rd_prev = epp_status_rd;
    if (epp_timeout_evt) begin
      next_s.timeout = 1'b1;
    end else if (timeout_clr) begin
      next_s.timeout = 1'b0;
    end

    // Register writes
    int_clr = '0;
    if (bus_wr) begin
      if (sel_pp && bus_addr == `PMCB_OFF_PP_MODE) begin
        next_s.pp_mode = bus_wdata;
      end
      if (sel_pp && bus_addr == `PMCB_OFF_PP_OPT) begin
        next_s.pp_opt = bus_wdata & `PMCB_PP_OPT_MASK;
      end
      if (sel_sp1 && bus_addr == `PMCB_OFF_SP1_MODE) begin
        next_s.sp1_mode = bus_wdata & `PMCB_SP1_MASK;
      end
      if (bus_addr == `PMCB_OFF_INT_STAT) begin
        int_clr = bus_wdata[`PMCB_INT_MSB:0];
      end
      if (bus_addr == `PMCB_OFF_INT_MASK) begin
        next_s.int_mask = bus_wdata[`PMCB_INT_MSB:0];
      end
    end

    // Read data stands for exactly one cycle
    next_s.rdata = `PMCB_BYTE_ZERO;
    if (bus_rd) begin
      if (sel_pp && bus_addr == `PMCB_OFF_PP_MODE) begin
        next_s.rdata = s.pp_mode;
      end else if (sel_pp && bus_addr == `PMCB_OFF_PP_OPT) begin
        next_s.rdata = s.pp_opt;
      end else if (sel_sp1 && bus_addr == `PMCB_OFF_SP1_MODE) begin
        next_s.rdata = s.sp1_mode;
      end else if (bus_addr == `PMCB_OFF_INT_STAT) begin
        next_s.rdata = {6'h00, s.int_stat};
      end else if (bus_addr == `PMCB_OFF_INT_MASK) begin
        next_s.rdata = {6'h00, s.int_mask};
      end
    end

    // Parallel interrupt pin
    if (basic || !itype) begin
      next_s.pulse_st = PS_IDLE;
      next_s.pulse_cnt = `PMCB_CNT_ZERO;
      next_s.pp_irq_out = req;
      next_s.pp_irq_oe = 1'b1;
    end else begin
      unique case (s.pulse_st)
        PS_IDLE: begin
          next_s.pp_irq_out = 1'b0;
          next_s.pp_irq_oe = 1'b0;
          if (trigger) begin
            next_s.pulse_st = PS_LOW;
            next_s.pulse_cnt = 3'(`PMCB_IRQ_PULSE_CYC - 1);
            next_s.pp_irq_oe = 1'b1;
          end
        end
        PS_LOW: begin
          next_s.pp_irq_out = 1'b0;
          if (s.pulse_cnt == `PMCB_CNT_ZERO) begin
            next_s.pulse_st = PS_IDLE;
            next_s.pp_irq_oe = 1'b0;
          end else begin
            next_s.pulse_cnt = s.pulse_cnt - 3'h1;
            next_s.pp_irq_oe = 1'b1;
          end
        end
        default: begin
          next_s.pulse_st = PS_IDLE;
          next_s.pp_irq_out = 1'b0;
          next_s.pp_irq_oe = 1'b0;
        end
      endcase
    end

    // Serial interrupts; sharing with both IRQs assigned still fans out
    if (s.sp1_mode[`PMCB_SP1_SHARE_BIT]) begin
      next_s.uart1_irq = uart1_irq_req || uart2_irq_req;
      next_s.uart2_irq = uart1_irq_req || uart2_irq_req;
    end else begin
      next_s.uart1_irq = uart1_irq_req;
      next_s.uart2_irq = uart2_irq_req;
    end

    // Sticky events, set wins over write-one-clear
    int_set = '0;
    int_set[`PMCB_INT_TIMEOUT_BIT] = epp_timeout_evt;
    int_set[`PMCB_INT_PPIRQ_BIT] = trigger;
    next_s.int_stat = (s.int_stat & ~int_clr) | int_set;
    next_s.cfg_irq = |(next_s.int_stat & next_s.int_mask);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s.pp_mode <= `PMCB_PP_MODE_RST;
      s.pp_opt <= `PMCB_PP_OPT_RST;
      s.sp1_mode <= `PMCB_SP1_RST;
      s.int_stat <= `PMCB_INT_RST;
      s.int_mask <= `PMCB_INT_RST;
      s.rdata <= `PMCB_BYTE_ZERO;
      s.timeout <= 1'b0;
      s.rd_prev <= 1'b0;
      s.req_prev <= 1'b0;
      s.pulse_st <= PS_IDLE;
      s.pulse_cnt <= `PMCB_CNT_ZERO;
      s.pp_irq_out <= 1'b0;
      s.pp_irq_oe <= 1'b1;
      s.uart1_irq <= 1'b0;
      s.uart2_irq <= 1'b0;
      s.cfg_irq <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign bus_rdata = s.rdata;
  assign pp_mode = s.pp_mode[`PMCB_PP_MODE_MSB:`PMCB_PP_MODE_LSB];
  assign ecp_fifo_threshold = s.pp_mode[`PMCB_PP_THR_MSB:`PMCB_PP_THR_LSB];
  assign epp_timeout_flag = s.timeout;
  assign pp_irq_out = s.pp_irq_out;
  assign pp_irq_oe = s.pp_irq_oe;
  assign uart1_midi_en = s.sp1_mode[`PMCB_SP1_MIDI_BIT];
  assign uart1_high_speed = s.sp1_mode[`PMCB_SP1_HS_BIT];
  assign uart1_irq = s.uart1_irq;
  assign uart2_irq = s.uart2_irq;
  assign cfg_irq = s.cfg_irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence pulse_start_s;
    trigger && itype && !basic && s.pulse_st == PS_IDLE;
  endsequence

  sequence pulse_body_s;
    (pp_irq_oe && !pp_irq_out) [*4] ##1 !pp_irq_oe;
  endsequence

  threshold_write_a: assert property (
    (bus_wr && sel_pp && bus_addr == `PMCB_OFF_PP_MODE)
      |=> ecp_fifo_threshold == $past(bus_wdata[`PMCB_PP_THR_MSB:`PMCB_PP_THR_LSB]))
    else $error("threshold not taken from write");

  pulse_shape_a: assert property (pulse_start_s |=> pulse_body_s)
    else $error("pulsed interrupt has wrong shape");

  level_follow_a: assert property (
    (!itype && (mode == PM_EPP19 || mode == PM_EPP17))
      |=> (pp_irq_oe && pp_irq_out == !$past(nack_s)))
    else $error("interrupt does not follow nack");

  basic_ignore_a: assert property (
    (basic && itype) |=> (pp_irq_oe && pp_irq_out == $past(req)))
    else $error("type bit not ignored in basic mode");

  timeout_write_a: assert property (
    (epp_timeout_flag && !tosel && !epp_timeout_evt && epp_status_wr
      && epp_status_wdata[`PMCB_EPP_TIMEOUT_BIT]) |=> !epp_timeout_flag)
    else $error("timeout flag not cleared by write");

  timeout_read_a: assert property (
    (epp_timeout_flag && tosel && $fell(epp_status_rd) && !epp_timeout_evt)
      |=> !epp_timeout_flag)
    else $error("timeout flag not cleared after read");

  timeout_keep_a: assert property (
    (epp_timeout_flag && tosel && !epp_timeout_evt && epp_status_wr && !$fell(epp_status_rd))
      |=> epp_timeout_flag)
    else $error("timeout flag cleared by write in read mode");

  serial_bits_a: assert property (
    (bus_wr && sel_sp1 && bus_addr == `PMCB_OFF_SP1_MODE)
      |=> (uart1_midi_en == $past(bus_wdata[`PMCB_SP1_MIDI_BIT])
        && uart1_high_speed == $past(bus_wdata[`PMCB_SP1_HS_BIT])))
    else $error("serial mode bits not taken");

  irq_own_a: assert property (
    !s.sp1_mode[`PMCB_SP1_SHARE_BIT] |=> (uart1_irq == $past(uart1_irq_req)
      && uart2_irq == $past(uart2_irq_req)))
    else $error("separate uart interrupts mixed");

  irq_share_a: assert property (
    (s.sp1_mode[`PMCB_SP1_SHARE_BIT] && (uart1_irq_req || uart2_irq_req))
      |=> (uart1_irq && uart2_irq))
    else $error("shared uart interrupt not on both");

  cfg_irq_a: assert property (
    (epp_timeout_evt && s.int_mask[`PMCB_INT_TIMEOUT_BIT] && !bus_wr)
      |=> cfg_irq ##1 (cfg_irq || $past(bus_wr)))
    else $error("sticky interrupt not raised");

  mode_write_a: assert property (
    (bus_wr && sel_pp && bus_addr == `PMCB_OFF_PP_MODE)
      |=> pp_mode == $past(bus_wdata[`PMCB_PP_MODE_MSB:`PMCB_PP_MODE_LSB]))
    else $error("mode field not taken from write");

  level_fifo_a: assert property (
    (!itype && pmcb_is_ecp(mode) && ecp_fifo_mode)
      |=> (pp_irq_oe && pp_irq_out == $past(pp_irq_req)))
    else $error("fifo interrupt not level type");

  pulse_release_a: assert property (
    (itype && !basic && s.pulse_st == PS_IDLE && !trigger) |=> !pp_irq_oe)
    else $error("pulsed interrupt line not released");

  pulse_hold_a: assert property (
    (s.pulse_st == PS_LOW && itype && !basic && s.pulse_cnt != `PMCB_CNT_ZERO)
      |=> (pp_irq_oe && !pp_irq_out))
    else $error("pulse cut short");

  timeout_set_a: assert property (
    epp_timeout_evt |=> epp_timeout_flag)
    else $error("timeout event lost");

  timeout_hold_a: assert property (
    (!tosel && !epp_timeout_evt && !epp_status_wr) |=> $stable(epp_timeout_flag))
    else $error("timeout flag changed without write");

  serial_hold_a: assert property (
    !(bus_wr && sel_sp1 && bus_addr == `PMCB_OFF_SP1_MODE)
      |=> $stable({uart1_midi_en, uart1_high_speed}))
    else $error("serial mode bits changed without write");

  share_quiet_a: assert property (
    (s.sp1_mode[`PMCB_SP1_SHARE_BIT] && !uart1_irq_req && !uart2_irq_req)
      |=> (!uart1_irq && !uart2_irq))
    else $error("shared uart interrupt without request");

  rdata_idle_a: assert property (
    !bus_rd |=> bus_rdata == `PMCB_BYTE_ZERO)
    else $error("read data stands too long");

  cfg_masked_a: assert property (
    (s.int_mask == `PMCB_INT_RST && !bus_wr) |=> !cfg_irq)
    else $error("masked event raised interrupt");

endmodule : pmcb_bank
`default_nettype wire

/* File: verification/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pmcb_pkg::*;
  typedef struct packed {
    logic [7:0] ldn;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
    logic [8:0] oexp;
  } pmcb_row_t;
  logic clk_sys, rst, bus_wr, bus_rd, nack_n, ecp_fifo_mode, pp_irq_req;
  logic epp_timeout_evt, epp_status_rd, epp_status_wr, uart1_irq_req, uart2_irq_req;
  logic [7:0] logical_device, bus_addr, bus_wdata, bus_rdata, epp_status_wdata, rd_val;
  logic [2:0] pp_mode;
  logic [3:0] ecp_fifo_threshold;
  logic epp_timeout_flag, pp_irq_out, pp_irq_oe, uart1_midi_en, uart1_high_speed;
  logic uart1_irq, uart2_irq, cfg_irq;
  int fails = 0;
  int n_compared = 0;
  int width;
  pmcb_row_t rows [18];
  pmcb_bank uut (.clk_sys(clk_sys), .rst(rst), .logical_device(logical_device),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .nack_n(nack_n), .ecp_fifo_mode(ecp_fifo_mode),
    .pp_irq_req(pp_irq_req), .epp_timeout_evt(epp_timeout_evt),
    .epp_status_rd(epp_status_rd), .epp_status_wr(epp_status_wr),
    .epp_status_wdata(epp_status_wdata), .uart1_irq_req(uart1_irq_req),
    .uart2_irq_req(uart2_irq_req), .pp_mode(pp_mode), .ecp_fifo_threshold(ecp_fifo_threshold),
    .epp_timeout_flag(epp_timeout_flag), .pp_irq_out(pp_irq_out), .pp_irq_oe(pp_irq_oe),
    .uart1_midi_en(uart1_midi_en), .uart1_high_speed(uart1_high_speed),
    .uart1_irq(uart1_irq), .uart2_irq(uart2_irq), .cfg_irq(cfg_irq));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] l, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    logical_device <= l;
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] l, input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    logical_device <= l;
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : rd
  task automatic pulse_evt();
    @(posedge clk_sys);
    epp_timeout_evt <= 1'b1;
    @(posedge clk_sys);
    epp_timeout_evt <= 1'b0;
    tick(1);
  endtask : pulse_evt
  task automatic status_wr(input logic [7:0] d);
    @(posedge clk_sys);
    epp_status_wr <= 1'b1;
    epp_status_wdata <= d;
    @(posedge clk_sys);
    epp_status_wr <= 1'b0;
    tick(2);
  endtask : status_wr
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #(25 * 5000);
    fails++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    {bus_wr, bus_rd, ecp_fifo_mode, pp_irq_req, epp_timeout_evt} = '0;
    {epp_status_rd, epp_status_wr, uart1_irq_req, uart2_irq_req} = '0;
    nack_n = 1'b1;
    logical_device = 8'h03;
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    epp_status_wdata = 8'h00;
    rows = '{'{8'h03, 8'hf0, 8'h04, 8'h04, {3'h4, 4'h0, 2'b00}},
      '{8'h03, 8'hf0, 8'h00, 8'h00, {3'h0, 4'h0, 2'b00}},
      '{8'h03, 8'hf0, 8'h01, 8'h01, {3'h1, 4'h0, 2'b00}},
      '{8'h03, 8'hf0, 8'h05, 8'h05, {3'h5, 4'h0, 2'b00}},
      '{8'h03, 8'hf0, 8'h02, 8'h02, {3'h2, 4'h0, 2'b00}},
      '{8'h03, 8'hf0, 8'h03, 8'h03, {3'h3, 4'h0, 2'b00}},
      '{8'h03, 8'hf0, 8'h07, 8'h07, {3'h7, 4'h0, 2'b00}},
      '{8'h03, 8'hf0, 8'h06, 8'h06, {3'h6, 4'h0, 2'b00}},
      '{8'h03, 8'hf0, 8'h7a, 8'h7a, {3'h2, 4'hf, 2'b00}},
      '{8'h03, 8'hf0, 8'h3c, 8'h3c, {3'h4, 4'h7, 2'b00}},
      '{8'h03, 8'hf1, 8'h10, 8'h10, {3'h4, 4'h7, 2'b00}},
      '{8'h03, 8'hf2, 8'haa, 8'h00, {3'h4, 4'h7, 2'b00}},
      '{8'h04, 8'hf0, 8'h83, 8'h83, {3'h4, 4'h7, 2'b11}},
      '{8'h04, 8'hf0, 8'h01, 8'h01, {3'h4, 4'h7, 2'b10}},
      '{8'h04, 8'hf0, 8'h02, 8'h02, {3'h4, 4'h7, 2'b01}},
      '{8'h05, 8'hf0, 8'h55, 8'h00, {3'h4, 4'h7, 2'b01}},
      '{8'h04, 8'hf0, 8'h00, 8'h00, {3'h4, 4'h7, 2'b00}},
      '{8'h03, 8'hf1, 8'h00, 8'h00, {3'h4, 4'h7, 2'b00}}};
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    tick(1);
    check("reset outputs", {pp_mode, ecp_fifo_threshold, epp_timeout_flag, pp_irq_oe}, 9'h11d);
    rd(8'h03, 8'hf0, rd_val);
    check("pp mode reset", {1'b0, rd_val}, 9'h03c);
    rd(8'h03, 8'hf1, rd_val);
    check("option reset", {1'b0, rd_val}, 9'h000);
    rd(8'h04, 8'hf0, rd_val);
    check("serial reset", {uart1_midi_en, rd_val}, 9'h000);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].ldn, rows[i].addr, rows[i].wdata);
      rd(rows[i].ldn, rows[i].addr, rd_val);
      check("readback", {1'b0, rd_val}, {1'b0, rows[i].rexp});
      check("decoded", {pp_mode, ecp_fifo_threshold, uart1_midi_en, uart1_high_speed},
        rows[i].oexp);
    end
    $display("test register table done");
    // Timeout flag, select zero, with masked then unmasked event interrupt
    wr(8'h03, 8'hff, 8'h00);
    pulse_evt();
    check("flag set", 9'({cfg_irq, epp_timeout_flag}), 9'h001);
    @(posedge clk_sys);
    epp_status_rd <= 1'b1;
    @(posedge clk_sys);
    epp_status_rd <= 1'b0;
    tick(2);
    status_wr(8'h00);
    check("flag kept", 9'(epp_timeout_flag), 9'h001);
    wr(8'h03, 8'hff, 8'h01);
    tick(2);
    check("irq unmasked", 9'(cfg_irq), 9'h001);
    status_wr(8'h01);
    check("flag cleared", 9'(epp_timeout_flag), 9'h000);
    rd(8'h03, 8'hfe, rd_val);
    check("status", {1'b0, rd_val}, 9'h001);
    wr(8'h03, 8'hfe, 8'h01);
    tick(2);
    check("irq cleared", 9'(cfg_irq), 9'h000);
    // Select one: write clear refused, read trailing edge clears
    wr(8'h03, 8'hf1, 8'h10);
    pulse_evt();
    status_wr(8'h01);
    check("write ignored", 9'(epp_timeout_flag), 9'h001);
    @(posedge clk_sys);
    epp_status_rd <= 1'b1;
    tick(2);
    check("held in read", 9'(epp_timeout_flag), 9'h001);
    @(posedge clk_sys);
    epp_status_rd <= 1'b0;
    tick(3);
    check("read cleared", 9'(epp_timeout_flag), 9'h000);
    $display("test timeout done");
    // Printer mode with type one stays a driven level
    wr(8'h03, 8'hf0, 8'hbc);
    nack_n <= 1'b0;
    tick(8);
    check("printer low", 9'({pp_irq_oe, pp_irq_out}), 9'h003);
    nack_n <= 1'b1;
    tick(6);
    check("printer high", 9'({pp_irq_oe, pp_irq_out}), 9'h002);
    wr(8'h03, 8'hf0, 8'hba);
    tick(4);
    nack_n <= 1'b0;
    for (int k = 0; k < 10 && pp_irq_oe !== 1'b1; k++) tick(1);
    width = 0;
    while (width < 10 && pp_irq_oe === 1'b1 && pp_irq_out === 1'b0) begin
      width++;
      tick(1);
    end
    check("pulse width", width[8:0], 9'h004);
    check("released", 9'(pp_irq_oe), 9'h000);
    nack_n <= 1'b1;
    wr(8'h03, 8'hf0, 8'h3a);
    ecp_fifo_mode <= 1'b1;
    pp_irq_req <= 1'b1;
    tick(3);
    check("level high", 9'({pp_irq_oe, pp_irq_out}), 9'h003);
    pp_irq_req <= 1'b0;
    tick(3);
    check("level low", 9'({pp_irq_oe, pp_irq_out}), 9'h002);
    ecp_fifo_mode <= 1'b0;
    nack_n <= 1'b0;
    tick(5);
    check("follows ack", 9'({pp_irq_oe, pp_irq_out}), 9'h003);
    nack_n <= 1'b1;
    $display("test parallel irq done");
    uart1_irq_req <= 1'b1;
    tick(3);
    check("own irqs", 9'({uart1_irq, uart2_irq}), 9'h002);
    wr(8'h04, 8'hf0, 8'h80);
    tick(2);
    check("shared one", 9'({uart1_irq, uart2_irq}), 9'h003);
    uart1_irq_req <= 1'b0;
    uart2_irq_req <= 1'b1;
    tick(3);
    check("shared two", 9'({uart1_irq, uart2_irq}), 9'h003);
    wr(8'h04, 8'hf0, 8'h00);
    tick(2);
    check("unshared", 9'({uart1_irq, uart2_irq}), 9'h001);
    $display("test uart irq done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
